// [verilog/smc_defs.svh]
// strap/mode configuration block: offsets, field positions, reset values and timing counts
`ifndef SMC_DEFS_SVH
`define SMC_DEFS_SVH
// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define SMC_STATUS_OFF 12'h000
`define SMC_CTRL_OFF 12'h004
`define SMC_GAIN_OFF 12'h008
`define SMC_VOL_OFF 12'h00c
// ----------------------------------------
// field positions
// ----------------------------------------
`define SMC_ST_ADDR_LSB 0
`define SMC_ST_SLOT_LSB 8
`define SMC_ST_RATE_LSB 16
`define SMC_ST_TWO_BIT 20
`define SMC_ST_MONO_BIT 21
`define SMC_ST_TDM_BIT 22
`define SMC_ST_SA_BIT 23
`define SMC_ST_DONE_BIT 31
`define SMC_CTRL_SPD_BIT 0
`define SMC_CTRL_MONO_BIT 4
`define SMC_GAIN_DB_LSB 8
`define SMC_VOL_CUR_LSB 8
`define SMC_VOL_RAMP_BIT 16
// ----------------------------------------
// reset and default values
// ----------------------------------------
`define SMC_GAIN_SW_RST 2'h2
`define SMC_GAIN_SA 2'h3
`define SMC_SPD_SW_RST 1'h1
`define SMC_ADDR_TOP 1'h1
`define SMC_VOL_RST 8'h40
`define SMC_VOL_MAX 8'hfa
`define SMC_DB_13 5'h0d
`define SMC_DB_16 5'h10
`define SMC_DB_19 5'h13
`define SMC_DB_21 5'h15
// ----------------------------------------
// timing
// ----------------------------------------
`define SMC_CLK_MHZ 250
`define SMC_SETTLE_NS 1000
`define SMC_SETTLE_CYC ((`SMC_SETTLE_NS * `SMC_CLK_MHZ + 999) / 1000)
`define SMC_RAMP_NS 400
`define SMC_RAMP_CYC ((`SMC_RAMP_NS * `SMC_CLK_MHZ) / 1000)
`endif

// [verilog/smc_pkg.sv]
// types shared by the strap/mode configuration block
package smc_pkg;
   typedef enum logic [2:0] {LV_GND, LV_PDN, LV_OPEN, LV_PUP, LV_SUP} smc_lvl_t;
   typedef enum logic [2:0] {RATE_8_12, RATE_16_24, RATE_32_48, RATE_64_96, RATE_128_192} smc_rate_t;
   typedef enum logic [2:0] {ST_SETTLE, ST_SYNC, ST_HI, ST_LO, ST_DONE} smc_state_t;
   typedef struct packed {
      logic standalone;
      smc_rate_t rate;
      logic mono;
      logic [3:0] slot_idx;
      logic force_pair;
      logic [4:0] dev_addr;
      logic tdm_fmt;
   } smc_cfg_t;
endpackage : smc_pkg

// [verilog/smc_top.sv]
// strap decode, standalone mode detection, mono routing, gain and volume with APB access
//
// The register addresses and the APB slave port were left to the implementer.
`timescale 1ns/10ps
`include "smc_defs.svh"
module smc_top import smc_pkg::*; (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic [11:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // straps and pins
   input wire logic [3:0] strap_pin_a,
   input wire logic [3:0] strap_pin_b,
   input wire logic sda_pin,
   input wire logic scl_pin,
   input wire logic frame_sync,
   // configuration out
   output logic cfg_done,
   output logic standalone_mode,
   output logic [4:0] dev_addr,
   output logic [4:0] slot_first,
   output logic two_slots,
   output logic [2:0] rate_sel,
   output logic tdm_format,
   output logic mono_mode,
   output logic [1:0] analog_gain_sel,
   output logic [4:0] gain_db,
   output logic soft_powerdown,
   output logic left_mod_en,
   output logic right_mod_en,
   output logic right_stage_from_left,
   output logic [7:0] vol_code,
   output logic vol_ramping
);
   // ----------------------------------------
   // decode functions
   // ----------------------------------------
   function automatic smc_lvl_t lvl_of(input logic [3:0] t);
      logic [2:0] n;
      n = {2'h0, t[0]} + {2'h0, t[1]} + {2'h0, t[2]} + {2'h0, t[3]};
      unique case (n)
         3'h0: lvl_of = LV_GND;
         3'h1: lvl_of = LV_PDN;
         3'h2: lvl_of = LV_OPEN;
         3'h3: lvl_of = LV_PUP;
         default: lvl_of = LV_SUP;
      endcase
   endfunction : lvl_of

   // order 0, 1, pull-down, pull-up
   function automatic logic [1:0] code_of(input smc_lvl_t l);
      unique case (l)
         LV_SUP: code_of = 2'h1;
         LV_PDN: code_of = 2'h2;
         LV_PUP: code_of = 2'h3;
         default: code_of = 2'h0;
      endcase
   endfunction : code_of

   function automatic logic [4:0] db_of(input logic [1:0] g);
      unique case (g)
         2'h0: db_of = `SMC_DB_13;
         2'h1: db_of = `SMC_DB_16;
         2'h2: db_of = `SMC_DB_19;
         default: db_of = `SMC_DB_21;
      endcase
   endfunction : db_of

   // ----------------------------------------
   // pin synchronisers
   // ----------------------------------------
   localparam int NPIN = 11;
   logic [NPIN-1:0] s1_q, s2_q, s3_q, filt_q, filt_d;
   logic fs_prev_q;
   genvar gi;
   generate
      for (gi = 0; gi < NPIN; gi++) begin : g_filt
         assign filt_d[gi] = (s2_q[gi] == s3_q[gi]) ? s2_q[gi] : filt_q[gi];
      end
   endgenerate
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s1_q <= '0;
         s2_q <= '0;
         s3_q <= '0;
         filt_q <= '0;
         fs_prev_q <= 1'b0;
      end else begin
         s1_q <= {frame_sync, scl_pin, sda_pin, strap_pin_b, strap_pin_a};
         s2_q <= s1_q;
         s3_q <= s2_q;
         filt_q <= filt_d;
         fs_prev_q <= filt_q[10];
      end
   end
   smc_lvl_t lvl_a, lvl_b;
   logic [1:0] code_a, code_b;
   logic sda_f, scl_f, fs_f, fs_rise;
   always_comb begin
      lvl_a = lvl_of(filt_q[3:0]);
      lvl_b = lvl_of(filt_q[7:4]);
      code_a = code_of(lvl_a);
      code_b = code_of(lvl_b);
      sda_f = filt_q[8];
      scl_f = filt_q[9];
      fs_f = filt_q[10];
      fs_rise = fs_f & ~fs_prev_q;
   end

   // ----------------------------------------
   // strap decode and format detection
   // ----------------------------------------
   smc_state_t state_q, state_d;
   smc_cfg_t cfg_q, cfg_d, strap_cfg;
   logic [15:0] cnt_q, cnt_d, hi_q, hi_d, lo_q, lo_d;
   logic tdm_calc;
   always_comb begin
      strap_cfg = '0;
      strap_cfg.rate = RATE_32_48;
      strap_cfg.standalone = (lvl_a == LV_OPEN) || (lvl_b == LV_OPEN);
      if (!strap_cfg.standalone) begin
         strap_cfg.slot_idx = {code_a[1], code_b[1], code_a[0], code_b[0]};
         strap_cfg.dev_addr = {`SMC_ADDR_TOP, strap_cfg.slot_idx};
      end else if (lvl_a == LV_OPEN && lvl_b == LV_OPEN) begin
         strap_cfg.force_pair = 1'b1;
         if (!sda_f) begin
            strap_cfg.rate = RATE_8_12;
            strap_cfg.mono = scl_f;
         end else begin
            strap_cfg.rate = scl_f ? RATE_128_192 : RATE_16_24;
         end
      end else begin
         strap_cfg.rate = sda_f ? RATE_64_96 : RATE_32_48;
         strap_cfg.mono = scl_f;
         strap_cfg.slot_idx = (lvl_b == LV_OPEN) ? {2'h0, code_a} : {2'h1, code_b};
      end
   end
   assign tdm_calc = {hi_q, 2'h0} < ({2'h0, hi_q} + {2'h0, lo_q});
   always_comb begin
      state_d = state_q;
      cfg_d = cfg_q;
      cnt_d = cnt_q;
      hi_d = hi_q;
      lo_d = lo_q;
      unique case (state_q)
         ST_SETTLE: begin
            cnt_d = cnt_q + 16'h1;
            if (cnt_q == 16'(`SMC_SETTLE_CYC - 1)) begin
               cfg_d = strap_cfg;
               state_d = strap_cfg.standalone ? ST_SYNC : ST_DONE;
            end
         end
         ST_SYNC: begin
            if (fs_rise) begin
               hi_d = 16'h1;
               lo_d = 16'h0;
               state_d = ST_HI;
            end
         end
         ST_HI: begin
            if (fs_f) begin
               hi_d = (&hi_q) ? hi_q : hi_q + 16'h1;
            end else begin
               lo_d = 16'h1;
               state_d = ST_LO;
            end
         end
         ST_LO: begin
            if (fs_rise) begin
               cfg_d.tdm_fmt = tdm_calc;
               state_d = ST_DONE;
            end else begin
               lo_d = (&lo_q) ? lo_q : lo_q + 16'h1;
            end
         end
         ST_DONE: state_d = ST_DONE;
      endcase
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= ST_SETTLE;
         cfg_q <= '0;
         cnt_q <= '0;
         hi_q <= '0;
         lo_q <= '0;
      end else begin
         state_q <= state_d;
         cfg_q <= cfg_d;
         cnt_q <= cnt_d;
         hi_q <= hi_d;
         lo_q <= lo_d;
      end
   end
   wire done_w = (state_q == ST_DONE);
   wire done_rise = done_w && !cfg_done;

   // ----------------------------------------
   // registers, apb slave, outputs
   // ----------------------------------------
   logic mono_q, mono_d, spd_q, spd_d, rdy_q, rdy_d, err_q, err_d, ramping_q, ramping_d;
   logic [1:0] gain_q, gain_d;
   logic [7:0] vtgt_q, vtgt_d, vcur_q, vcur_d, rcnt_q, rcnt_d;
   logic [31:0] rd_q, rd_d, status_w;
   logic [4:0] slot_d;
   logic setup, wr_ok, mapped, sw_wr;
   always_comb begin
      status_w = '0;
      status_w[`SMC_ST_ADDR_LSB +: 5] = cfg_q.dev_addr;
      status_w[`SMC_ST_SLOT_LSB +: 5] = slot_first;
      status_w[`SMC_ST_RATE_LSB +: 3] = cfg_q.rate;
      status_w[`SMC_ST_TWO_BIT] = two_slots;
      status_w[`SMC_ST_MONO_BIT] = mono_q;
      status_w[`SMC_ST_TDM_BIT] = cfg_q.tdm_fmt;
      status_w[`SMC_ST_SA_BIT] = cfg_q.standalone;
      status_w[`SMC_ST_DONE_BIT] = done_w;
      setup = psel && !penable;
      mapped = paddr == `SMC_STATUS_OFF || paddr == `SMC_CTRL_OFF || paddr == `SMC_GAIN_OFF || paddr == `SMC_VOL_OFF;
      wr_ok = psel && penable && rdy_q && pwrite && mapped;
      sw_wr = wr_ok && done_w && !cfg_q.standalone;
      rdy_d = setup;
      err_d = setup && !mapped;
      rd_d = rd_q;
      if (setup) begin
         rd_d = '0;
         if (!pwrite && paddr == `SMC_STATUS_OFF) rd_d = status_w;
         if (!pwrite && paddr == `SMC_CTRL_OFF) begin
            rd_d[`SMC_CTRL_SPD_BIT] = spd_q;
            rd_d[`SMC_CTRL_MONO_BIT] = mono_q;
         end
         if (!pwrite && paddr == `SMC_GAIN_OFF) rd_d = {19'h0, db_of(gain_q), 6'h0, gain_q};
         if (!pwrite && paddr == `SMC_VOL_OFF) rd_d = {15'h0, ramping_q, vcur_q, vtgt_q};
      end
      mono_d = mono_q;
      spd_d = spd_q;
      gain_d = gain_q;
      vtgt_d = vtgt_q;
      if (done_rise) begin
         mono_d = cfg_q.standalone ? cfg_q.mono : 1'b0;
         spd_d = cfg_q.standalone ? 1'b0 : `SMC_SPD_SW_RST;
         gain_d = cfg_q.standalone ? `SMC_GAIN_SA : `SMC_GAIN_SW_RST;
      end
      if (sw_wr && paddr == `SMC_CTRL_OFF) begin
         spd_d = pwdata[`SMC_CTRL_SPD_BIT];
         mono_d = pwdata[`SMC_CTRL_MONO_BIT];
      end
      if (sw_wr && paddr == `SMC_GAIN_OFF) gain_d = pwdata[1:0];
      if (wr_ok && paddr == `SMC_VOL_OFF) begin
         vtgt_d = (pwdata[7:0] > `SMC_VOL_MAX) ? `SMC_VOL_MAX : pwdata[7:0];
      end
      // one 0.375 dB step per ramp period
      vcur_d = vcur_q;
      rcnt_d = (vcur_q == vtgt_q || rcnt_q == 8'(`SMC_RAMP_CYC - 1)) ? 8'h0 : rcnt_q + 8'h1;
      if (rcnt_q == 8'(`SMC_RAMP_CYC - 1)) begin
         if (vcur_q < vtgt_q) vcur_d = vcur_q + 8'h1;
         if (vcur_q > vtgt_q) vcur_d = vcur_q - 8'h1;
      end
      ramping_d = vcur_d != vtgt_d;
      slot_d = (mono_q && !cfg_q.force_pair) ? {1'b0, cfg_q.slot_idx} + 5'h1 : {cfg_q.slot_idx, 1'b1};
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mono_q <= 1'b0;
         spd_q <= `SMC_SPD_SW_RST;
         gain_q <= `SMC_GAIN_SW_RST;
         gain_db <= `SMC_DB_19;
         vtgt_q <= `SMC_VOL_RST;
         vcur_q <= `SMC_VOL_RST;
         rcnt_q <= '0;
         ramping_q <= 1'b0;
         rdy_q <= 1'b0;
         err_q <= 1'b0;
         rd_q <= '0;
         cfg_done <= 1'b0;
         slot_first <= 5'h1;
         two_slots <= 1'b1;
         left_mod_en <= 1'b0;
         right_mod_en <= 1'b0;
         right_stage_from_left <= 1'b0;
      end else begin
         mono_q <= mono_d;
         spd_q <= spd_d;
         gain_q <= gain_d;
         gain_db <= db_of(gain_d);
         vtgt_q <= vtgt_d;
         vcur_q <= vcur_d;
         rcnt_q <= rcnt_d;
         ramping_q <= ramping_d;
         rdy_q <= rdy_d;
         err_q <= err_d;
         rd_q <= rd_d;
         cfg_done <= done_w;
         slot_first <= slot_d;
         two_slots <= !mono_q || cfg_q.force_pair;
         left_mod_en <= done_w && !spd_q;
         right_mod_en <= done_w && !spd_q && !mono_q;
         right_stage_from_left <= mono_q;
      end
   end
   assign prdata = rd_q;
   assign pready = rdy_q;
   assign pslverr = err_q;
   assign standalone_mode = cfg_q.standalone;
   assign dev_addr = cfg_q.dev_addr;
   assign rate_sel = cfg_q.rate;
   assign tdm_format = cfg_q.tdm_fmt;
   assign mono_mode = mono_q;
   assign analog_gain_sel = gain_q;
   assign soft_powerdown = spd_q;
   assign vol_code = vcur_q;
   assign vol_ramping = ramping_q;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   chk_addr_range: assert property (done_w && !cfg_q.standalone |-> dev_addr >= 5'h10)
      else $error("device address below range");
   chk_cfg_frozen: assert property (done_w && $past(done_w) |-> $stable(cfg_q))
      else $error("configuration changed after latch");
   chk_sa_gain: assert property ($rose(done_w) && cfg_q.standalone |=> gain_q == 2'h3 && !spd_q)
      else $error("standalone gain or powerdown default wrong");
   chk_fmt_detect: assert property (state_q == ST_LO && fs_rise |=> cfg_q.tdm_fmt == $past(tdm_calc))
      else $error("frame format mismatch");
   chk_rate_pin: assert property (done_w && cfg_q.standalone && !cfg_q.force_pair
      |-> (cfg_q.rate == RATE_64_96) || (cfg_q.rate == RATE_32_48))
      else $error("rate group wrong with one strap open");
   chk_pair_fixed: assert property (done_w && cfg_q.force_pair |=> slot_first == 5'h1 && two_slots)
      else $error("both-open slot pair wrong");
   chk_mono_route: assert property (mono_q && done_w |=> !right_mod_en && right_stage_from_left)
      else $error("mono routing wrong");
   chk_gain_db: assert property (gain_q == 2'h2 |-> gain_db == 5'h13)
      else $error("gain decode wrong");
   chk_sw_gain: assert property ($rose(done_w) && !cfg_q.standalone |=> gain_q == 2'h2)
      else $error("software gain default wrong");
   chk_vol_step: assert property (vcur_q != $past(vcur_q) |-> $past(rcnt_q) == 8'(`SMC_RAMP_CYC - 1))
      else $error("volume stepped off the ramp period");
   cov_standalone: cover property ($rose(done_w) && cfg_q.standalone);
   cov_tdm: cover property (done_w && cfg_q.tdm_fmt);
   cov_mono: cover property (done_w && mono_q);
   cov_ramp_done: cover property ($fell(ramping_q));
endmodule : smc_top

// [sim/smc_strap_model.sv]
// board strap wiring and frame sync source facing the strap decoder
`timescale 1ns/10ps
module smc_strap_model (
   // clock
   input wire logic pclk,
   // board settings chosen by the bench
   input wire logic [2:0] lvl_a,
   input wire logic [2:0] lvl_b,
   input wire logic sda_lvl,
   input wire logic scl_lvl,
   input wire logic fs_on,
   input wire logic fs_tdm,
   // pins
   output logic [3:0] strap_pin_a,
   output logic [3:0] strap_pin_b,
   output logic sda_pin,
   output logic scl_pin,
   output logic frame_sync
);
   logic [4:0] fs_cnt_q = 5'h00;
   // ----------------------------------------
   // straps as comparator thermometer codes
   // ----------------------------------------
   assign strap_pin_a = 4'((5'h01 << lvl_a) - 5'h01);
   assign strap_pin_b = 4'((5'h01 << lvl_b) - 5'h01);
   // serial pins tied to a rail in standalone
   assign sda_pin = sda_lvl;
   assign scl_pin = scl_lvl;
   // ----------------------------------------
   // frame sync: half period high or two-cycle pulse
   // pulse spans two clocks so the pin filter keeps it
   // ----------------------------------------
   always_ff @(posedge pclk) begin
      fs_cnt_q <= fs_cnt_q + 5'h01;
   end
   assign frame_sync = fs_on && (fs_tdm ? (fs_cnt_q[4:1] == 4'h0) : fs_cnt_q[4]);
endmodule : smc_strap_model

// [sim/test_strap_mode_config_and_gain.sv]
// self-checking bench for strap decode, gain, mono routing and volume
`timescale 1ns/10ps
module test_strap_mode_config_and_gain;
   // flg bits: sda scl tdm standalone two_slots mono
   typedef struct {
      logic [2:0] la;
      logic [2:0] lb;
      logic [5:0] flg;
      logic [4:0] addr;
      logic [4:0] slot;
      logic [2:0] rate;
   } smc_row_t;
   localparam logic [2:0] lg = 3'h0;
   localparam logic [2:0] ld = 3'h1;
   localparam logic [2:0] lo = 3'h2;
   localparam logic [2:0] lu = 3'h3;
   localparam logic [2:0] ls = 3'h4;
   smc_row_t rows [17] = '{
      '{lg, lg, 6'h32, 5'h10, 5'h01, 3'h0}, '{lg, ls, 6'h32, 5'h11, 5'h03, 3'h0},
      '{ld, lu, 6'h32, 5'h1d, 5'h1b, 3'h0}, '{lu, ld, 6'h32, 5'h1e, 5'h1d, 3'h0},
      '{ls, ls, 6'h32, 5'h13, 5'h07, 3'h0}, '{lg, lo, 6'h06, 5'h00, 5'h01, 3'h2},
      '{ls, lo, 6'h1d, 5'h00, 5'h02, 3'h2}, '{ld, lo, 6'h26, 5'h00, 5'h05, 3'h3},
      '{lu, lo, 6'h3d, 5'h00, 5'h04, 3'h3}, '{lo, lg, 6'h0e, 5'h00, 5'h09, 3'h2},
      '{lo, ls, 6'h15, 5'h00, 5'h06, 3'h2}, '{lo, ld, 6'h2e, 5'h00, 5'h0d, 3'h3},
      '{lo, lu, 6'h35, 5'h00, 5'h08, 3'h3}, '{lo, lo, 6'h06, 5'h00, 5'h01, 3'h0},
      '{lo, lo, 6'h1f, 5'h00, 5'h01, 3'h0}, '{lo, lo, 6'h26, 5'h00, 5'h01, 3'h1},
      '{lo, lo, 6'h3e, 5'h00, 5'h01, 3'h4}};
   logic [4:0] db_exp [4] = '{5'h0d, 5'h10, 5'h13, 5'h15};
   smc_row_t r;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic er, sda_l, scl_l, fs_on, fs_tdm;
   logic [2:0] lv_a, lv_b;
   logic [3:0] strap_pin_a, strap_pin_b;
   logic sda_pin, scl_pin, frame_sync, cfg_done, standalone_mode, two_slots, tdm_format, mono_mode;
   logic soft_powerdown, left_mod_en, right_mod_en, right_stage_from_left, vol_ramping;
   logic [4:0] dev_addr, slot_first, gain_db;
   logic [2:0] rate_sel;
   logic [1:0] analog_gain_sel;
   logic [7:0] vol_code;
   int n_mismatch = 0;
   int n_checks = 0;
   int cyc;
   smc_top i_smc_top (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
      .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .strap_pin_a(strap_pin_a), .strap_pin_b(strap_pin_b), .sda_pin(sda_pin), .scl_pin(scl_pin),
      .frame_sync(frame_sync), .cfg_done(cfg_done), .standalone_mode(standalone_mode), .dev_addr(dev_addr),
      .slot_first(slot_first), .two_slots(two_slots), .rate_sel(rate_sel), .tdm_format(tdm_format),
      .mono_mode(mono_mode), .analog_gain_sel(analog_gain_sel), .gain_db(gain_db),
      .soft_powerdown(soft_powerdown), .left_mod_en(left_mod_en), .right_mod_en(right_mod_en),
      .right_stage_from_left(right_stage_from_left), .vol_code(vol_code), .vol_ramping(vol_ramping));
   smc_strap_model i_smc_strap_model (.pclk(pclk), .lvl_a(lv_a), .lvl_b(lv_b), .sda_lvl(sda_l),
      .scl_lvl(scl_l), .fs_on(fs_on), .fs_tdm(fs_tdm), .strap_pin_a(strap_pin_a),
      .strap_pin_b(strap_pin_b), .sda_pin(sda_pin), .scl_pin(scl_pin), .frame_sync(frame_sync));
   always #2 pclk = ~pclk;
   // ----------------------------------------
   // shared tasks
   // ----------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      n_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1 && n < 20) begin
         @(posedge pclk);
         n++;
      end
      chk(pready, 32'h1, "pready");
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic do_reset();
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      for (cyc = 0; cyc < 600 && cfg_done !== 1'b1; cyc++) @(posedge pclk);
      @(negedge pclk);
   endtask : do_reset
   task automatic close_out();
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : close_out
   initial begin
      #200000;
      n_mismatch++;
      close_out();
   end
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      pclk = 1'b0;
      presetn = 1'b0;
      {psel, penable, pwrite, paddr, pwdata} = '0;
      {lv_a, lv_b, sda_l, scl_l, fs_on, fs_tdm} = {lo, lo, 4'h2};
      foreach (rows[k]) begin
         r = rows[k];
         @(posedge pclk);
         {lv_a, lv_b, sda_l, scl_l, fs_tdm} <= {r.la, r.lb, r.flg[5:3]};
         do_reset();
         chk(32'(cyc >= 250), 32'h1, "sample time");
         chk({cfg_done, standalone_mode}, {1'b1, r.flg[2]}, "mode");
         chk(dev_addr, r.addr, "addr");
         chk({slot_first, two_slots}, {r.slot, r.flg[1]}, "slots");
         chk({mono_mode, right_stage_from_left}, {2{r.flg[0]}}, "mono");
         if (r.flg[0]) chk(right_mod_en, 32'h0, "right off");
         chk(left_mod_en, 32'(r.flg[2]), "left on");
         if (r.flg[2]) begin
            chk({rate_sel, tdm_format}, {r.rate, r.flg[3]}, "rate fmt");
            chk({soft_powerdown, analog_gain_sel, gain_db}, {1'b0, 2'h3, 5'h15}, "sa gain");
         end else begin
            chk({analog_gain_sel, gain_db}, {2'h2, 5'h13}, "sw gain");
         end
         apb(1'b0, 12'h000, 32'h0);
         chk({rd[31], rd[23], rd[12:8], rd[4:0]}, {1'b1, r.flg[2], r.slot, r.addr}, "status");
      end
      // latched straps ignore later changes; standalone refuses gain writes
      @(posedge pclk);
      {lv_a, lv_b, sda_l} <= {lg, lu, 1'b0};
      apb(1'b1, 12'h008, 32'h0);
      repeat (300) @(posedge pclk);
      @(negedge pclk);
      chk({rate_sel, slot_first, standalone_mode}, {3'h4, 5'h01, 1'b1}, "latched");
      chk(analog_gain_sel, 32'h3, "sa gain write");
      // standalone without frame sync never completes
      @(posedge pclk);
      {lv_a, fs_on} <= {lo, 1'b0};
      do_reset();
      chk(cfg_done, 32'h0, "no frame sync");
      // reset values, then software mode
      @(posedge pclk);
      {lv_a, lv_b, fs_on} <= {lg, lg, 1'b1};
      presetn <= 1'b0;
      @(negedge pclk);
      chk({cfg_done, vol_code, slot_first, analog_gain_sel}, {1'b0, 8'h40, 5'h01, 2'h2}, "reset");
      do_reset();
      apb(1'b0, 12'h004, 32'h0);
      chk(rd[4], 32'h0, "ctrl reset");
      for (int g = 0; g < 4; g++) begin
         apb(1'b1, 12'h008, 32'(g));
         apb(1'b0, 12'h008, 32'h0);
         chk({rd[12:8], gain_db}, {db_exp[g], db_exp[g]}, "gain");
      end
      apb(1'b1, 12'h004, 32'h10);
      apb(1'b0, 12'h004, 32'h0);
      chk({rd[4], mono_mode, right_mod_en, right_stage_from_left, left_mod_en}, 32'h1b, "mono set");
      apb(1'b1, 12'h000, 32'h0);
      apb(1'b0, 12'h010, 32'h0);
      chk(er, 32'h1, "unmapped");
      apb(1'b0, 12'h000, 32'h0);
      chk({er, rd[31]}, 32'h1, "status read only");
      // volume ramps one step at a time, target clamped
      apb(1'b1, 12'h00c, 32'h42);
      repeat (50) @(posedge pclk);
      @(negedge pclk);
      chk(vol_ramping, 32'h1, "ramping");
      for (int i = 0; i < 1000 && vol_ramping !== 1'b0; i++) @(posedge pclk);
      @(negedge pclk);
      chk({vol_code, vol_ramping}, {8'h42, 1'b0}, "ramp end");
      apb(1'b1, 12'h00c, 32'hff);
      apb(1'b0, 12'h00c, 32'h0);
      chk(rd[7:0], 32'hfa, "vol clamp");
      apb(1'b1, 12'h004, 32'h1);
      close_out();
   end
endmodule : test_strap_mode_config_and_gain
